// ### ext_irq_pin_change_flags.sv
// flag, mask and request logic for two external pins and sixteen pin-change inputs
// Operation
// - upper group change requests pins 11:8
// - reserved mask and flag bits read zero
// - edge on pin one sets bit 7
// - edge on pin zero sets bit 6
// - request needs flag, enable and global enable; low-level sensing needs no flag
// - routine entry clears its flag
// - writing one clears a flag
// - low-level sensing holds pin flag zero
// - enabled pin change sets shared bit 5
// - low mask gates pins 7:0, lower group
// - high mask splits upper/lower group by nibble
// - cleared mask bit blocks its pin
// - two-bit sense field selects pin trigger
// - mask bits 7,6 enable external pins
// - mask bit 5 enables lower group
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module ext_irq_pin_change_flags (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ext_pin_zero,
  input  wire logic        ext_pin_one,
  input  wire logic [15:0] pc_input_pins,
  input  wire logic        ack_ext_zero,
  input  wire logic        ack_ext_one,
  input  wire logic        ack_pc,
  output logic             req_ext_zero,
  output logic             req_ext_one,
  output logic             req_pc,
  output logic             irq
);
  logic [7:0]  pc_mask_hi_register;
  logic [7:0]  pc_mask_lo_register;
  logic [7:0]  irq_mask_register;
  logic [7:0]  irq_flag_register;
  logic [7:0]  sense_ctrl_register;
  logic [7:0]  cpu_status_word;
  logic [15:0] pc_sync1;
  logic [15:0] pc_sync2;
  logic [15:0] pc_prev;

  // =====================================================================
  // register map, one byte per word in bits 7:0
  //   22  pin-change mask, pins 15:8
  //   23  pin-change mask, pins 7:0
  //   3c  enables: 7 pin one, 6 pin zero, 5 lower group, 4 upper group
  //   40  flags: 7 pin one, 6 pin zero, 5 pin change; a one clears
  //   44  sense: 1:0 pin zero, 3:2 pin one
  //   48  status word, 7 global enable
  //   4c  clear only, same layout as the flags, reads zero
  // unmapped offsets read zero and ignore writes, so software probing the
  // map never disturbs a flag by accident

  // =====================================================================
  // wishbone decode
  wire        access   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr_lane0 = access & wb_we_i & wb_sel_i[0];
  wire        hit_mhi  = wb_adr_i == ext_irq_pkg::pc_mask_hi_register_addr;
  wire        hit_mlo  = wb_adr_i == ext_irq_pkg::pc_mask_lo_register_addr;
  wire        hit_msk  = wb_adr_i == ext_irq_pkg::irq_mask_register_addr;
  wire        hit_flg  = wb_adr_i == ext_irq_pkg::irq_flag_register_addr;
  wire        hit_sns  = wb_adr_i == ext_irq_pkg::sense_ctrl_register_addr;
  wire        hit_csw  = wb_adr_i == ext_irq_pkg::cpu_status_word_addr;
  wire        hit_clr  = wb_adr_i == ext_irq_pkg::irq_clear_register_addr;
  wire [7:0]  wdat     = wb_dat_i[7:0];

  // reserved mask and flag bits are masked on read; unmapped and write-only read zero
  wire [7:0]  rd_byte =
      hit_mhi ? pc_mask_hi_register :
      hit_mlo ? pc_mask_lo_register :
      hit_msk ? (irq_mask_register & ext_irq_pkg::irq_mask_used) :
      hit_flg ? (irq_flag_register & ext_irq_pkg::irq_flag_used) :
      hit_sns ? sense_ctrl_register :
      hit_csw ? cpu_status_word :
      ext_irq_pkg::zero_byte;

  // =====================================================================
  // external pins
  logic trig_zero;
  logic trig_one;
  logic low_zero;
  logic low_one;

  ext_pin_detect u_det_zero (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .pin       (ext_pin_zero),
    .sense     (sense_ctrl_register[1:0]),
    .trigger   (trig_zero),
    .low_level (low_zero)
  );

  ext_pin_detect u_det_one (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .pin       (ext_pin_one),
    .sense     (sense_ctrl_register[3:2]),
    .trigger   (trig_one),
    .low_level (low_one)
  );

  wire level_zero = sense_ctrl_register[1:0] == ext_irq_pkg::sense_low;
  wire level_one  = sense_ctrl_register[3:2] == ext_irq_pkg::sense_low;

  // =====================================================================
  // pin-change detection
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_sync1 <= 16'h0000;
      pc_sync2 <= 16'h0000;
      pc_prev  <= 16'h0000;
    end else begin
      pc_sync1 <= pc_input_pins;
      pc_sync2 <= pc_sync1;
      pc_prev  <= pc_sync2;
    end
  end

  wire        upper_en = irq_mask_register[ext_irq_pkg::pc_upper_en_bit];
  wire        lower_en = irq_mask_register[ext_irq_pkg::pc_lower_en_bit];
  // group gate per pin: 7:0 and 15:12 lower, 11:8 upper
  wire [15:0] group_gate = {{4{lower_en}}, {4{upper_en}}, {8{lower_en}}};
  wire [15:0] pin_mask   = {pc_mask_hi_register, pc_mask_lo_register};
  wire [15:0] pc_diff    = pc_sync2 ^ pc_prev;
  wire        pc_event   = |(pc_diff & pin_mask & group_gate);

  // =====================================================================
  // flag update: set wins over every clear
  wire [7:0] clr_wr = (wr_lane0 & (hit_flg | hit_clr)) ? wdat : ext_irq_pkg::zero_byte;
  wire [7:0] clr_ack = {ack_ext_one, ack_ext_zero, ack_pc, 5'h00};
  wire [7:0] set_ev  = {trig_one, trig_zero, pc_event, 5'h00};
  wire [7:0] hold_lv = {level_one, level_zero, 6'h00};
  wire [7:0] next_flag =
      ((irq_flag_register & ~clr_wr & ~clr_ack) | set_ev) & ~hold_lv & ext_irq_pkg::irq_flag_used;

  // =====================================================================
  // requests: flag, matching enable and global enable
  wire g_en = cpu_status_word[ext_irq_pkg::global_en_bit];
  // low-level sensing requests while the pin is held low, without a flag
  wire next_req_zero = g_en & irq_mask_register[ext_irq_pkg::ext_zero_bit] &
                       (level_zero ? low_zero : next_flag[ext_irq_pkg::ext_zero_bit]);
  wire next_req_one  = g_en & irq_mask_register[ext_irq_pkg::ext_one_bit] &
                       (level_one ? low_one : next_flag[ext_irq_pkg::ext_one_bit]);
  wire next_req_pc   = g_en & (upper_en | lower_en) & next_flag[ext_irq_pkg::pc_lower_en_bit];

  // =====================================================================
  // write strobes, one per writable register apart from the flag and clear offsets
  // writes land on the taking edge, so the ack edge already shows the value
  wire wr_mhi = wr_lane0 & hit_mhi;
  wire wr_mlo = wr_lane0 & hit_mlo;
  wire wr_msk = wr_lane0 & hit_msk;
  wire wr_sns = wr_lane0 & hit_sns;
  wire wr_csw = wr_lane0 & hit_csw;

  // =====================================================================
  // merged request
  // irq is rebuilt from the next values so it rises on the same edge as
  // the requests and never lags them by a cycle
  wire next_irq = next_req_zero | next_req_one | next_req_pc;

  // =====================================================================
  // pin-change mask, pins 15:8
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_mask_hi_register <= ext_irq_pkg::pc_mask_hi_reset;
    end else if (wr_mhi) begin
      pc_mask_hi_register <= wdat;
    end
  end

  // =====================================================================
  // pin-change mask, pins 7:0
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_mask_lo_register <= ext_irq_pkg::pc_mask_lo_reset;
    end else if (wr_mlo) begin
      pc_mask_lo_register <= wdat;
    end
  end

  // =====================================================================
  // enable register
  // reserved bits are never stored, so no later decode can see stale ones
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask_register <= ext_irq_pkg::zero_byte;
    end else if (wr_msk) begin
      irq_mask_register <= wdat & ext_irq_pkg::irq_mask_used;
    end
  end

  // =====================================================================
  // sense control
  // changing the sense does not create an edge; the history stage keeps
  // running whatever the mode is
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sense_ctrl_register <= ext_irq_pkg::zero_byte;
    end else if (wr_sns) begin
      sense_ctrl_register <= wdat;
    end
  end

  // =====================================================================
  // status word holding the global enable
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_status_word <= ext_irq_pkg::zero_byte;
    end else if (wr_csw) begin
      cpu_status_word <= wdat;
    end
  end

  // =====================================================================
  // flags
  // a set in the same cycle as a clear wins, so no event is ever lost
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_flag_register <= ext_irq_pkg::zero_byte;
    end else begin
      irq_flag_register <= next_flag;
    end
  end

  // =====================================================================
  // request for pin zero
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_ext_zero <= 1'b0;
    end else begin
      req_ext_zero <= next_req_zero;
    end
  end

  // =====================================================================
  // request for pin one
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_ext_one <= 1'b0;
    end else begin
      req_ext_one <= next_req_one;
    end
  end

  // =====================================================================
  // request for the shared pin-change vector
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_pc <= 1'b0;
    end else begin
      req_pc <= next_req_pc;
    end
  end

  // =====================================================================
  // merged interrupt line
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // =====================================================================
  // bus answer: one wait-free ack a cycle after the strobe
  // ack drops on its own even if the master keeps the strobe high, since
  // access is gated by the ack itself
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= access;
    end
  end

  // =====================================================================
  // read data
  // zero outside the ack cycle, so a late sample can never pass as data
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_dat_o <= access ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// ### ext_irq_pin_change_flags_assertions.sv
// port checks for the interrupt flag block
`timescale 1ns/10ps
`default_nettype none
module ext_irq_pin_change_flags_assertions (
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [15:0] pc_input_pins,
  input wire logic        ack_pc,
  input wire logic        req_ext_zero,
  input wire logic        req_ext_one,
  input wire logic        req_pc,
  input wire logic        irq
);
  // ====
  // cycles since the pin-change inputs last moved; guards against sync pipeline in flight
  logic [3:0]  quiet;
  logic [15:0] last_pins;
  wire         rd_ack = wb_ack_o && !wb_we_i;
  wire         clr_pc = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_dat_i[5] &&
                        (wb_adr_i == ext_irq_pkg::irq_flag_register_addr ||
                         wb_adr_i == ext_irq_pkg::irq_clear_register_addr);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      quiet     <= 4'h0;
      last_pins <= 16'h0;
    end else begin
      last_pins <= pc_input_pins;
      quiet     <= (pc_input_pins != last_pins) ? 4'h0 : ((quiet == 4'hf) ? quiet : quiet + 4'h1);
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ====
  // checks
  bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack late or longer than one cycle");
  data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  mask_rsv_a: assert property (rd_ack && wb_adr_i == ext_irq_pkg::irq_mask_register_addr |-> wb_dat_o[3:0] == 4'h0)
    else $error("mask reserved bits not zero");
  flag_rsv_a: assert property (rd_ack && wb_adr_i == ext_irq_pkg::irq_flag_register_addr |-> wb_dat_o[4:0] == 5'h0)
    else $error("flag reserved bits not zero");
  irq_merge_a: assert property (irq == (req_ext_zero || req_ext_one || req_pc))
    else $error("irq differs from request merge");
  svc_clear_a: assert property (ack_pc && quiet > 4'h6 |=> !req_pc)
    else $error("pin change request kept after service");
  write_clear_a: assert property (clr_pc && quiet > 4'h6 |=> !req_pc)
    else $error("pin change request kept after write clear");
  pc_cause_a: assert property ($rose(req_pc) |-> quiet < 4'h7 || wb_ack_o || $past(wb_ack_o))
    else $error("pin change request without cause");
endmodule
bind ext_irq_pin_change_flags ext_irq_pin_change_flags_assertions u_ext_irq_pin_change_flags_assertions (
  .core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .pc_input_pins(pc_input_pins), .ack_pc(ack_pc), .req_ext_zero(req_ext_zero), .req_ext_one(req_ext_one),
  .req_pc(req_pc), .irq(irq));
`default_nettype wire

// ### ext_irq_pkg.sv
// constants for the external and pin-change interrupt block
package ext_irq_pkg;
  // =====================================================================
  // register map (byte addresses on the wishbone slave)
  localparam logic [7:0] pc_mask_hi_register_addr  = 8'h22;
  localparam logic [7:0] pc_mask_lo_register_addr  = 8'h23;
  localparam logic [7:0] irq_mask_register_addr    = 8'h3c;
  localparam logic [7:0] irq_flag_register_addr    = 8'h40;
  localparam logic [7:0] sense_ctrl_register_addr  = 8'h44;
  localparam logic [7:0] cpu_status_word_addr      = 8'h48;
  localparam logic [7:0] irq_clear_register_addr   = 8'h4c;
  // =====================================================================
  // field positions
  localparam int ext_one_bit      = 7;
  localparam int ext_zero_bit     = 6;
  localparam int pc_lower_en_bit  = 5;
  localparam int pc_upper_en_bit  = 4;
  localparam int global_en_bit    = 7;
  // =====================================================================
  // reset values and bit masks
  localparam logic [7:0] pc_mask_hi_reset = 8'hff;
  localparam logic [7:0] pc_mask_lo_reset = 8'hc8;
  localparam logic [7:0] zero_byte        = 8'h00;
  localparam logic [7:0] irq_mask_used    = 8'hf0;
  localparam logic [7:0] irq_flag_used    = 8'he0;
  localparam logic [7:0] pc_upper_group   = 8'h0f;
  // =====================================================================
  // sense control encodings
  typedef enum logic [1:0] {
    sense_low     = 2'h0,
    sense_any     = 2'h1,
    sense_falling = 2'h2,
    sense_rising  = 2'h3
  } sense_t;
endpackage

// ### ext_pin_detect.sv
// edge and level detector for one external interrupt pin
`timescale 1ns/10ps
`default_nettype none
module ext_pin_detect (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       pin,
  input  wire logic [1:0] sense,
  output logic            trigger,
  output logic            low_level
);
  logic sync1;
  logic sync2;
  logic prev;

  // =====================================================================
  // two-stage synchroniser, then one history stage for edges
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev  <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  wire rise = sync2 & ~prev;
  wire fall = ~sync2 & prev;

  always_comb begin
    trigger   = 1'b0;
    low_level = 1'b0;
    case (ext_irq_pkg::sense_t'(sense))
      ext_irq_pkg::sense_low:     low_level = ~sync2;
      ext_irq_pkg::sense_any:     trigger = rise | fall;
      ext_irq_pkg::sense_falling: trigger = fall;
      ext_irq_pkg::sense_rising:  trigger = rise;
      default:                    trigger = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ### ext_pin_partner.sv
// model of the external pins feeding the interrupt block
`timescale 1ns/10ps
`default_nettype none
module ext_pin_partner (
  input  wire logic        core_clk,
  input  wire logic [17:0] want,
  output logic      [17:0] pins
);
  // ====
  // pins settle one clock after they are commanded, like a slow driver
  always @(posedge core_clk) pins <= want;
endmodule
`default_nettype wire

// ### test_ext_irq_pin_change_flags.sv
// self-checking bench for the interrupt flag block
`timescale 1ns/10ps
`default_nettype none
module test_ext_irq_pin_change_flags;
  logic        core_clk = 1'b0, rst_b = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic        ack_ext_zero = 1'b0, ack_ext_one = 1'b0, ack_pc = 1'b0;
  logic [17:0] want = 18'h10000;
  logic [17:0] pins;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, req_ext_zero, req_ext_one, req_pc, irq;
  int          errors = 0, checked = 0;
  always #4 core_clk = ~core_clk;
  ext_pin_partner u_ext_pin_partner (.core_clk(core_clk), .want(want), .pins(pins));
  ext_irq_pin_change_flags u_ext_irq_pin_change_flags (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_pin_zero(pins[16]), .ext_pin_one(pins[17]),
    .pc_input_pins(pins[15:0]), .ack_ext_zero(ack_ext_zero), .ack_ext_one(ack_ext_one), .ack_pc(ack_pc),
    .req_ext_zero(req_ext_zero), .req_ext_one(req_ext_one), .req_pc(req_pc), .irq(irq));
  // ====
  // shared tasks
  task results;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task check(input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task xfer(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    @(posedge core_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, 24'h0, d};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (n >= 20) begin
      errors++;
      results();
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 8'h00, q);
    check({24'h0, exp}, q);
  endtask
  task pins_to(input logic [17:0] v);
    @(posedge core_clk);
    want <= v;
    repeat (5) @(posedge core_clk);
  endtask
  task outs(input logic [3:0] exp);
    @(posedge core_clk);
    check({28'h0, exp}, {28'h0, irq, req_ext_one, req_ext_zero, req_pc});
  endtask
  task svc(input logic [2:0] k);
    @(posedge core_clk);
    {ack_ext_one, ack_ext_zero, ack_pc} <= k;
    @(posedge core_clk);
    {ack_ext_one, ack_ext_zero, ack_pc} <= 3'h0;
    @(posedge core_clk);
  endtask
  // ====
  // scenarios
  task t_reset;
    rd(8'h22, 8'hff);
    rd(8'h23, 8'hc8);
    rd(8'h3c, 8'h00);
    rd(8'h40, 8'h00);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    rd(8'h4c, 8'h00);
  endtask
  task t_pc;
    wr(8'h48, 8'h80);
    wr(8'h3c, 8'h30);
    pins_to(18'h10008);
    outs(4'h9);
    rd(8'h40, 8'h20);
    svc(3'h1);
    outs(4'h0);
    pins_to(18'h10009);
    outs(4'h0);
    wr(8'h3c, 8'h20);
    pins_to(18'h10109);
    outs(4'h0);
    pins_to(18'h11109);
    outs(4'h9);
    wr(8'h40, 8'h00);
    rd(8'h40, 8'h20);
    wr(8'h40, 8'h20);
    rd(8'h40, 8'h00);
    wr(8'h3c, 8'h10);
    pins_to(18'h11009);
    outs(4'h9);
    wr(8'h48, 8'h00);
    outs(4'h0);
    wr(8'h40, 8'h20);
  endtask
  task t_ext;
    wr(8'h48, 8'h80);
    wr(8'h3c, 8'hc0);
    wr(8'h44, 8'h0e);
    pins_to(18'h21009);
    outs(4'he);
    rd(8'h40, 8'hc0);
    svc(3'h2);
    rd(8'h40, 8'h80);
    wr(8'h4c, 8'h80);
    rd(8'h40, 8'h00);
    wr(8'h44, 8'h04);
    outs(4'ha);
    rd(8'h40, 8'h00);
    pins_to(18'h11009);
    outs(4'hc);
    rd(8'h40, 8'h80);
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset();
    t_pc();
    t_ext();
    results();
  end
endmodule
`default_nettype wire
